// ===== hw/acc_clk_div.sv
// converter clock divider: system clock over 2, 4, 8 or 16
// assumes an asynchronous active-low reset already released cleanly
`timescale 1ns/1ns
module acc_clk_div
  import acc_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ACC_SEL_DIV_W-1:0] div_code,
  output logic clk_out
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] half_cnt;
  logic [ACC_SEL_DIV_W-1:0] code_eff;
  logic clk_r;

  generate
    if (CNT_W < 4) begin : g_bad_width
      $error("acc_clk_div: CNT_W must be at least 4");
    end
  endgenerate

  // codes above 011 clamp to divide by 16
  always_comb begin
    code_eff = (div_code > ACC_DIV_MAX_CODE) ? ACC_DIV_MAX_CODE : div_code; // RULE7
    half_cnt = CNT_W'((1 << code_eff) - 1); // RULE7
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      clk_r <= 1'b0;
    end else if (cnt_r >= half_cnt) begin
      cnt_r <= '0;
      clk_r <= ~clk_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign clk_out = clk_r;

endmodule // acc_clk_div

// ===== hw/acc_conv_ctrl.sv
// converter control: registers, start and finish sequencing, result capture
// assumes avalon-mm master on sys_clk and an analog core holding its result
// stable from before core_done rises until the next start
`timescale 1ns/1ns
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int ADDR_W = ACC_ADDR_W,
  parameter int DIV_CNT_W = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ACC_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [ACC_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  output logic irq,
  output acc_core_req_t core_req,
  output logic core_clk,
  output logic [ACC_SEL_AIN_W-1:0] ain_enable,
  input wire logic core_done,
  input wire logic [ACC_RES_W-1:0] core_result
);

  generate
    if (ADDR_W < 12) begin : g_bad_addr
      $error("acc_conv_ctrl: ADDR_W must be at least 12");
    end
    if (DIV_CNT_W < 4) begin : g_bad_div
      $error("acc_conv_ctrl: DIV_CNT_W must be at least 4");
    end
    if (ACC_RES_W != 9) begin : g_bad_res
      $error("acc_conv_ctrl: result pairing needs a 9-bit core result");
    end
  endgenerate

  // reset release
  logic [1:0] rst_pipe_r;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe_r <= 2'b00;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_r[1];

  // core input synchronisers
  logic done_meta_r;
  logic done_sync_r;
  logic done_prev_r;
  logic [ACC_RES_W-1:0] result_meta_r;
  logic [ACC_RES_W-1:0] result_sync_r;
  logic done_rise;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_meta_r <= 1'b0;
      done_sync_r <= 1'b0;
      done_prev_r <= 1'b0;
      result_meta_r <= '0;
      result_sync_r <= '0;
    end else begin
      done_meta_r <= core_done;
      done_sync_r <= done_meta_r;
      done_prev_r <= done_sync_r;
      result_meta_r <= core_result;
      result_sync_r <= result_meta_r;
    end
  end

  assign done_rise = done_sync_r & ~done_prev_r;

  // bus decode
  logic [9:0] reg_idx;
  logic addr_hi_zero;
  logic bus_req;
  logic sel_ctrl;
  logic sel_result;
  logic sel_clksel;
  logic sel_stat;
  logic sel_mask;
  logic mapped;
  logic wr_commit;
  logic [7:0] wr_byte;
  acc_ctrl_t wr_ctrl;

  logic avs_waitrequest_r;
  logic [ACC_DATA_W-1:0] avs_readdata_r;
  logic [1:0] avs_response_r;

  always_comb begin
    reg_idx = avs_address[11:2];
    addr_hi_zero = (avs_address >> 12) == '0;
    bus_req = avs_read | avs_write;
    wr_commit = avs_write & ~avs_waitrequest_r & avs_byteenable[0];
    wr_byte = avs_writedata[7:0];
    wr_ctrl = acc_ctrl_t'(wr_byte);
  end

  // register select, upper address bits must be zero
  always_comb begin
    sel_ctrl = 1'b0;
    sel_result = 1'b0;
    sel_clksel = 1'b0;
    sel_stat = 1'b0;
    sel_mask = 1'b0;
    if (addr_hi_zero) begin
      case (reg_idx)
        ACC_IDX_CTRL: begin
          sel_ctrl = 1'b1;
        end
        ACC_IDX_RESULT: begin
          sel_result = 1'b1;
        end
        ACC_IDX_CLKSEL: begin
          sel_clksel = 1'b1;
        end
        ACC_IDX_IRQ_STAT: begin
          sel_stat = 1'b1;
        end
        ACC_IDX_IRQ_MASK: begin
          sel_mask = 1'b1;
        end
        default: begin
          sel_ctrl = 1'b0;
        end
      endcase
    end
    mapped = sel_ctrl | sel_result | sel_clksel | sel_stat | sel_mask;
  end

  // registers
  acc_ctrl_t ctrl_r;
  logic [7:0] result_r;
  logic [7:0] clksel_r;
  logic [ACC_IRQ_W-1:0] irq_stat_r;
  logic [ACC_IRQ_W-1:0] irq_mask_r;
  logic irq_r;
  acc_state_t state_r;
  acc_core_req_t core_req_r;

  logic start_go;
  logic finish_go;
  logic abort_go;

  // a conversion starts only from idle with enable and request set
  assign start_go = (state_r == ACC_IDLE) && ctrl_r.enable && ctrl_r.request; // RULE9
  assign finish_go = (state_r == ACC_RUN) && done_rise;
  assign abort_go = (state_r == ACC_RUN) && !ctrl_r.enable && !done_rise;

  // wait one cycle, then answer for one cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_r <= 1'b1;
    end else begin
      avs_waitrequest_r <= ~(bus_req & avs_waitrequest_r);
    end
  end

  // response: decode error for unmapped addresses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_response_r <= ACC_RESP_OKAY;
    end else if (bus_req && avs_waitrequest_r) begin
      avs_response_r <= mapped ? ACC_RESP_OKAY : ACC_RESP_DECERR;
    end
  end

  // read data loaded at the request edge, held until the next request
  logic [ACC_DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (avs_read) begin
      if (sel_ctrl) begin
        rd_mux[7:0] = {ctrl_r[7:2], 1'b0, ctrl_r.result_lsb};
      end else if (sel_result) begin
        rd_mux[7:0] = result_r;
      end else if (sel_clksel) begin
        rd_mux[7:0] = {1'b0, clksel_r[6:0]};
      end else if (sel_stat) begin
        rd_mux[ACC_IRQ_W-1:0] = irq_stat_r;
      end else if (sel_mask) begin
        rd_mux[ACC_IRQ_W-1:0] = irq_mask_r;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_r <= '0;
    end else if (bus_req && avs_waitrequest_r) begin
      avs_readdata_r <= rd_mux;
    end
  end

  // conversion sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ACC_IDLE;
    end else begin
      case (state_r)
        ACC_IDLE: begin
          if (start_go) begin
            state_r <= ACC_RUN;
          end
        end
        ACC_RUN: begin
          if (finish_go || abort_go) begin
            state_r <= ACC_IDLE;
          end
        end
        default: begin
          state_r <= ACC_IDLE;
        end
      endcase
    end
  end

  // control register; hardware updates after software so they win
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= acc_ctrl_t'(ACC_CTRL_RST); // RULE3
    end else begin
      if (wr_commit && sel_ctrl) begin
        ctrl_r.enable <= wr_ctrl.enable;
        ctrl_r.request <= wr_ctrl.request;
        ctrl_r.irq_flag <= wr_ctrl.irq_flag; // RULE4
        ctrl_r.channel <= wr_ctrl.channel;
        ctrl_r.result_lsb <= wr_ctrl.result_lsb;
      end
      if (start_go) begin
        ctrl_r.finished <= 1'b0; // RULE2
      end
      // abort ends like a finish, flag included
      if (abort_go) begin
        ctrl_r.finished <= 1'b1; // RULE3
        ctrl_r.request <= 1'b0; // RULE1
        ctrl_r.irq_flag <= 1'b1; // RULE9
      end
      if (finish_go) begin
        ctrl_r.finished <= 1'b1; // RULE3
        ctrl_r.request <= 1'b0; // RULE1
        ctrl_r.irq_flag <= 1'b1; // RULE9
        ctrl_r.result_lsb <= result_sync_r[0]; // RULE6
      end
      ctrl_r.reserved <= 1'b0;
    end
  end

  // result register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= ACC_RESULT_RST;
    end else if (finish_go) begin
      result_r <= result_sync_r[ACC_RES_W-1:1]; // RULE6
    end
  end

  // clock divider and input enable register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clksel_r <= ACC_CLKSEL_RST;
    end else if (wr_commit && sel_clksel) begin
      clksel_r <= {1'b0, wr_byte[6:0]};
    end
  end

  // each enable connects its pin to the converter
  assign ain_enable = clksel_r[ACC_SEL_AIN_LSB +: ACC_SEL_AIN_W]; // RULE8

  acc_clk_div #(
    .CNT_W(DIV_CNT_W)
  ) u_clk_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .div_code(clksel_r[ACC_SEL_DIV_LSB +: ACC_SEL_DIV_W]), // RULE7
    .clk_out(core_clk)
  );

  // core request: start pulse and channel held for the conversion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_req_r <= '0;
    end else begin
      core_req_r.start <= start_go;
      if (start_go) begin
        core_req_r.channel <= ctrl_r.channel; // RULE5
      end
    end
  end

  // sticky event status, write one to clear, set wins
  logic [ACC_IRQ_W-1:0] irq_set;
  logic [ACC_IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[ACC_IRQ_DONE_BIT] = finish_go;
    irq_set[ACC_IRQ_START_BIT] = start_go;
  end

  always_comb begin
    irq_clr = (wr_commit && sel_stat) ? wr_byte[ACC_IRQ_W-1:0] : '0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= ACC_IRQ_RST;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_r <= ACC_IRQ_RST;
    end else if (wr_commit && sel_mask) begin
      irq_mask_r <= wr_byte[ACC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign avs_waitrequest = avs_waitrequest_r;
  assign avs_readdata = avs_readdata_r;
  assign avs_response = avs_response_r;
  assign irq = irq_r;
  assign core_req = core_req_r;

endmodule // acc_conv_ctrl

// ===== include/acc_pkg.sv
// constants, carrier types and state codes of the converter control block
// assumes a 32-bit avalon-mm slave port and a 9-bit analog converter core
//
// Contract
// (RULE1) finishing a conversion clears the start request in the same edge
// (RULE2) finished status drops to 0 at start and stays 0 while converting
// (RULE3) finished status rises on completion, is read-only, reads 1 after reset
// (RULE4) converter interrupt flag is cleared only by a software write of 0
// (RULE5) channel field bits 3:2 route input 0..3 for codes 00..11
// (RULE6) result bits 8:1 go to result register, bit 0 to control bit 0
// (RULE7) divider code 000..011 divides clock by 2,4,8,16; code 100 by 16
// (RULE8) each analog input has an enable bit connecting its port pin
// (RULE9) start needs enable and request both 1; flag rises with finished status
package acc_pkg;

  localparam int ACC_DATA_W = 32;
  localparam int ACC_ADDR_W = 12;
  localparam int ACC_RES_W = 9;

  // register indexes, byte address is four times the index
  localparam logic [9:0] ACC_IDX_CTRL = 10'h0ef;
  localparam logic [9:0] ACC_IDX_RESULT = 10'h0f8;
  localparam logic [9:0] ACC_IDX_CLKSEL = 10'h0f9;
  localparam logic [9:0] ACC_IDX_IRQ_STAT = 10'h0fa;
  localparam logic [9:0] ACC_IDX_IRQ_MASK = 10'h0fb;

  // reset values
  localparam logic [7:0] ACC_CTRL_RST = 8'h20;
  localparam logic [7:0] ACC_CLKSEL_RST = 8'h00;
  localparam logic [7:0] ACC_RESULT_RST = 8'h00;
  localparam logic [1:0] ACC_IRQ_RST = 2'h0;

  // clock select layout
  localparam int ACC_SEL_DIV_LSB = 4;
  localparam int ACC_SEL_DIV_W = 3;
  localparam int ACC_SEL_AIN_LSB = 0;
  localparam int ACC_SEL_AIN_W = 4;
  localparam logic [2:0] ACC_DIV_MAX_CODE = 3'h3;

  // interrupt status layout
  localparam int ACC_IRQ_DONE_BIT = 0;
  localparam int ACC_IRQ_START_BIT = 1;
  localparam int ACC_IRQ_W = 2;

  // avalon response codes
  localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACC_RESP_DECERR = 2'h3;

  typedef struct packed {
    logic enable;
    logic request;
    logic finished;
    logic irq_flag;
    logic [1:0] channel;
    logic reserved;
    logic result_lsb;
  } acc_ctrl_t;

  typedef struct packed {
    logic start;
    logic [1:0] channel;
  } acc_core_req_t;

  typedef enum logic {ACC_IDLE, ACC_RUN} acc_state_t;

endpackage

// ===== tb/acc_conv_ctrl_checker.sv
// port checker for the converter control block
// assumes it is bound to acc_conv_ctrl
`timescale 1ns/1ns
module acc_checker
  import acc_pkg::*;
#(
  parameter int ADDR_W = ACC_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ACC_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire acc_core_req_t core_req,
  input wire logic core_done
);
  wire logic rq = avs_read | avs_write;
  wire logic [9:0] ix = avs_address[11:2];
  wire logic ok = ix == ACC_IDX_CTRL || (ix >= ACC_IDX_RESULT && ix <= ACC_IDX_IRQ_MASK);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_WAIT_ONE: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  AST_WAIT_LOW1: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_WAIT_IDLE: assert property (!rq |-> avs_waitrequest)
    else $error("waitrequest low without request");
  AST_RESP_OK: assert property (!avs_waitrequest && ok |-> avs_response == ACC_RESP_OKAY)
    else $error("bad response on mapped address");
  AST_RESP_DEC: assert property (!avs_waitrequest && !ok |-> avs_response == ACC_RESP_DECERR)
    else $error("no decode error on unmapped address");
  AST_RD_HIGH: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_RD_RSV: assert property (!avs_waitrequest && avs_read && ix == ACC_IDX_CTRL |-> !avs_readdata[1])
    else $error("reserved control bit reads one");
  AST_START_PULSE: assert property ($rose(core_req.start) |=> $fell(core_req.start))
    else $error("start not a single pulse");
  AST_START_GAP: assert property (core_req.start |=> (!core_req.start) [*3])
    else $error("start repeated too soon");
  AST_CHAN_HOLD: assert property (!core_req.start |-> $stable(core_req.channel))
    else $error("channel moved outside a start");
  COV_START: cover property (core_req.start);
  COV_DONE: cover property ($rose(core_done));
  COV_DEC: cover property (!avs_waitrequest && !ok);
endmodule // acc_checker
bind acc_conv_ctrl acc_checker #(.ADDR_W(ADDR_W)) acc_checker_i (.sys_clk(sys_clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .core_req(core_req), .core_done(core_done));

// ===== tb/acc_core_model.sv
// behavioural analog core: converts the selected input after a set delay
// assumes start pulses from the control block on sys_clk
`timescale 1ns/1ns
module acc_core_model
  import acc_pkg::*;
(
  input wire logic sys_clk,
  input wire acc_core_req_t core_req,
  input wire logic [3:0] ain_enable,
  input wire logic [7:0] lat,
  input wire logic [3:0][8:0] ch_val,
  output logic core_done,
  output logic [8:0] core_result
);
  int cnt = -1;
  initial core_done = 1'h0;
  initial core_result = 9'h0;
  always @(posedge sys_clk) begin
    if (core_req.start) begin
      core_done <= 1'h0;
      cnt <= lat;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt > 4) begin
        core_result <= ~core_result;
      end else begin
        core_result <= ain_enable[core_req.channel] ? ch_val[core_req.channel] : 9'h0;
      end
    end else if (cnt == 0) begin
      core_done <= 1'h1;
      cnt <= -1;
    end
  end
endmodule // acc_core_model

// ===== tb/tb.sv
// self-checking bench of the converter control block
// assumes the core model stands on the far side
`timescale 1ns/1ns
module tb;
  import acc_pkg::*;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic [11:0] avs_address = 12'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, irq, core_clk, core_done;
  logic [1:0] avs_response;
  acc_core_req_t core_req;
  logic [3:0] ain_enable;
  logic [8:0] core_result;
  logic [7:0] lat = 8'h06;
  logic [3:0][8:0] ch_val = '0;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  localparam logic [11:0] A_CTL = {ACC_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_RES = {ACC_IDX_RESULT, 2'h0};
  localparam logic [11:0] A_SEL = {ACC_IDX_CLKSEL, 2'h0};
  localparam logic [11:0] A_STA = {ACC_IDX_IRQ_STAT, 2'h0};
  localparam logic [11:0] A_MSK = {ACC_IDX_IRQ_MASK, 2'h0};
  acc_conv_ctrl #(.DIV_CNT_W(4)) acc_conv_ctrl_i (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .irq(irq), .core_req(core_req), .core_clk(core_clk),
    .ain_enable(ain_enable), .core_done(core_done), .core_result(core_result));
  acc_core_model acc_core_model_i (.sys_clk(sys_clk), .core_req(core_req), .ain_enable(ain_enable),
    .lat(lat), .ch_val(ch_val), .core_done(core_done), .core_result(core_result));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      final_report;
    end
  end
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic rd, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata[7:0];
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'h0, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'h1, a, 8'h0, q);
    chk(q, e);
  endtask
  initial begin
    int code, en, v, ch;
    logic [7:0] cs;
    v = $urandom(49);
    repeat (12) @(posedge sys_clk);
    resetn <= 1'h1;
    repeat (3) @(posedge sys_clk);
    rd(A_CTL, 8'h20);
    rd(A_RES, 8'h0);
    rd(A_SEL, 8'h0);
    rd(A_MSK, 8'h0);
    rd(12'h0, 8'h0);
    $display("reset test done");
    for (code = 0; code < 5; code++) begin
      en = $urandom % 16;
      wr(A_SEL, 8'(code * 16 + en));
      rd(A_SEL, 8'(code * 16 + en));
      chk(ain_enable, en);
      repeat (2) @(posedge core_clk);
      @(negedge sys_clk) v = cyc;
      @(posedge core_clk);
      @(negedge sys_clk) chk(cyc - v, 2 << (code > 3 ? 3 : code));
    end
    $display("divider test done");
    wr(A_SEL, 8'h0f);
    wr(A_MSK, 8'h01);
    wr(A_CTL, 8'h40);
    repeat (6) @(posedge sys_clk);
    rd(A_CTL, 8'h60);
    for (ch = 0; ch < 4; ch++) begin
      v = $urandom % 512;
      cs = 8'(ch << 2);
      ch_val[ch] <= v[8:0];
      lat <= ch[0] ? 8'h28 : 8'h06;
      wr(A_CTL, 8'hc0 | cs);
      rd(A_CTL, 8'hc0 | cs);
      chk(core_req.channel, ch);
      wait (irq === 1'h1);
      rd(A_CTL, 8'hb0 | cs | v[0]);
      rd(A_RES, v[8:1]);
      rd(A_STA, 8'h03);
      repeat (20) @(posedge sys_clk);
      rd(A_CTL, 8'hb0 | cs | v[0]);
      wr(A_CTL, 8'h80 | cs | v[0]);
      wr(A_STA, 8'h03);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'h0);
      rd(A_CTL, 8'ha0 | cs | v[0]);
    end
    $display("conversion test done");
    wr(A_MSK, 8'h00);
    wr(A_CTL, 8'hc0);
    repeat (60) @(posedge sys_clk);
    chk(irq, 1'h0);
    rd(A_STA, 8'h03);
    $display("mask test done");
    wr(A_CTL, 8'hc0);
    wr(A_CTL, 8'h00);
    rd(A_CTL, 8'h30);
    $display("abort test done");
    final_report;
  end
endmodule // tb
